// *** hw/bsr_core.sv ***
// module: decode and execute of jump, call, skip, return and config-load
`timescale 1ns/1ns
`default_nettype none
// Contract
// - jump loads eleven-bit literal into pc bits 10:0
// - jump fills pc bits 12:11 from high latch bits 4:3
// - jump takes two cycles; pc written in Q4, second cycle idle
// - decrement register; result to working reg if dest 0, else register
// - zero result discards next instruction, runs idle cycle instead
// - interrupt return pops stack and loads top into pc
// - interrupt return sets global enable in Q3, pops in Q4
// - interrupt return takes two cycles, second fully idle
// - config-load copies working reg to timer config, one cycle, no flags
// - call pushes pc plus one, then loads literal into pc 10:0
// - bit-test set skips next instruction with an idle cycle
module bsr_core (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // program memory
  input wire logic [13:0] insn,
  output logic [12:0] pc,
  // data register file
  output logic [6:0] file_addr,
  input wire logic [7:0] file_rdata,
  output logic [7:0] file_wdata,
  output logic file_we,
  // latch from software
  input wire logic [7:0] pc_high_latch,
  // architectural state
  output logic [7:0] work_reg,
  output logic [7:0] timer_cfg,
  output logic [7:0] irq_control_reg,
  output logic global_irq_enable,
  output logic [1:0] phase,
  output logic idle_cycle
);
  bsr_stack_if stk ();
  bsr_stack u_stack (
    .clk(clk),
    .srst(srst),
    .sp(stk.stack)
  );

  bsr_pkg::bsr_phase_type ph_r;
  logic [bsr_pkg::PC_W-1:0] pc_r;
  logic [13:0] ir_r;
  logic idle_r;
  logic skip_r;
  logic [7:0] opnd_r;
  logic [7:0] res_r;
  logic [7:0] w_r;
  logic [7:0] cfg_r;
  logic [7:0] ictl_r;
  logic [7:0] fwd_r;
  logic fwe_r;
  // decode nets
  wire is_jump;
  wire is_call;
  wire is_dec;
  wire is_btss;
  wire is_iret;
  wire is_lcfg;
  wire dest_f;
  wire [2:0] bit_sel;
  wire [7:0] dec_val;
  wire bit_set;
  wire [12:0] pc_inc;
  wire [12:0] pc_lit;
  wire active;
  wire at_q2;
  wire at_q3;
  wire at_q4;
  wire skip_hit;
  // q4 selection nets
  wire load_lit;
  wire load_top;
  wire hold_pc;
  wire [12:0] pc_nxt;
  wire idle_nxt;
  wire skip_nxt;
  wire w_load;
  wire f_load;
  wire cfg_load;

  // opcode match on the latched instruction
  assign is_jump = (ir_r[13:11] == bsr_pkg::OPC_JUMP);
  assign is_call = (ir_r[13:11] == bsr_pkg::OPC_CALL);
  assign is_dec = (ir_r[13:8] == bsr_pkg::OPC_DECSKIP);
  assign is_btss = (ir_r[13:10] == bsr_pkg::OPC_BITSKIP);
  assign is_iret = (ir_r == bsr_pkg::OPC_IRQRET);
  assign is_lcfg = (ir_r == bsr_pkg::OPC_LOADCFG);

  // operand fields and arithmetic
  assign dest_f = ir_r[bsr_pkg::DEST_BIT];
  assign bit_sel = ir_r[9:7];
  assign dec_val = opnd_r - 8'h01;
  assign bit_set = opnd_r[bit_sel];
  assign pc_inc = pc_r + 13'h0001;
  assign pc_lit = {pc_high_latch[bsr_pkg::LATCH_HI_BIT:bsr_pkg::LATCH_LO_BIT],
    ir_r[bsr_pkg::LIT_W-1:0]};

  // phase strobes; in an idle cycle only the Q1 latch and the Q4 pc and idle update act
  assign active = !idle_r;
  assign at_q2 = (ph_r == bsr_pkg::BSR_Q2);
  assign at_q3 = (ph_r == bsr_pkg::BSR_Q3);
  assign at_q4 = (ph_r == bsr_pkg::BSR_Q4);

  // skip condition from decrement result or tested bit
  assign skip_hit = (is_dec && (res_r == 8'h00)) || (is_btss && bit_set);

  // q4 selection: branch target, stack top, held target or next address
  assign load_lit = active && (is_jump || is_call);
  assign load_top = active && is_iret;
  assign hold_pc = !active && !skip_r; // branch idle cycle must not step past the target
  assign pc_nxt = load_lit ? pc_lit : load_top ? stk.top : hold_pc ? pc_r : pc_inc;
  assign idle_nxt = load_lit || load_top || (active && skip_hit);
  assign skip_nxt = active && skip_hit; // skipped word is stepped over in the idle cycle
  assign w_load = active && is_dec && !dest_f;
  assign f_load = active && is_dec && dest_f;
  assign cfg_load = active && is_lcfg;

  // stack controls: push in Q2 of call, pop in Q4 of return
  assign stk.push = active && at_q2 && is_call;
  assign stk.push_data = pc_inc;
  assign stk.pop = active && at_q4 && is_iret;

  // phase sequencer Q1..Q4
  always_ff @(posedge clk) begin
    if (srst) begin
      ph_r <= bsr_pkg::BSR_Q1;
    end else begin
      case (ph_r)
        bsr_pkg::BSR_Q1: ph_r <= bsr_pkg::BSR_Q2;
        bsr_pkg::BSR_Q2: ph_r <= bsr_pkg::BSR_Q3;
        bsr_pkg::BSR_Q3: ph_r <= bsr_pkg::BSR_Q4;
        default: ph_r <= bsr_pkg::BSR_Q1;
      endcase
    end
  end

  // q1 decode: latch the instruction word
  always_ff @(posedge clk) begin
    if (srst) begin
      ir_r <= 14'h0000;
    end else if (ph_r == bsr_pkg::BSR_Q1) begin
      ir_r <= insn;
    end
  end

  // Q2 operand read
  always_ff @(posedge clk) begin
    if (srst) begin
      opnd_r <= 8'h00;
    end else if (active && at_q2) begin
      opnd_r <= file_rdata;
    end
  end

  // Q3 processing
  always_ff @(posedge clk) begin
    if (srst) begin
      res_r <= 8'h00;
      ictl_r <= bsr_pkg::IRQCTL_RESET;
    end else if (active && at_q3) begin
      res_r <= dec_val;
      if (is_iret) begin
        ictl_r[bsr_pkg::GIE_BIT] <= 1'b1;
      end
    end
  end

  // q4 write of pc, idle flag and skip kind; idle covers all four phases
  always_ff @(posedge clk) begin
    if (srst) begin
      pc_r <= bsr_pkg::PC_RESET;
      idle_r <= 1'b0;
      skip_r <= 1'b0;
    end else if (at_q4) begin
      pc_r <= pc_nxt;
      idle_r <= idle_nxt;
      skip_r <= skip_nxt;
    end
  end

  // q4 write of the working register
  always_ff @(posedge clk) begin
    if (srst) begin
      w_r <= 8'h00;
    end else if (at_q4 && w_load) begin
      w_r <= res_r;
    end
  end

  // q4 write of the timer config, no flags touched
  always_ff @(posedge clk) begin
    if (srst) begin
      cfg_r <= bsr_pkg::CFG_RESET;
    end else if (at_q4 && cfg_load) begin
      cfg_r <= w_r;
    end
  end

  // file write: one-clock pulse after q4
  always_ff @(posedge clk) begin
    if (srst) begin
      fwd_r <= 8'h00;
      fwe_r <= 1'b0;
    end else begin
      fwe_r <= at_q4 && f_load;
      if (at_q4 && f_load) begin
        fwd_r <= res_r;
      end
    end
  end

  // outputs straight from flops
  assign pc = pc_r;
  assign file_addr = ir_r[bsr_pkg::FADDR_W-1:0];
  assign file_wdata = fwd_r;
  assign file_we = fwe_r;
  assign work_reg = w_r;
  assign timer_cfg = cfg_r;
  assign irq_control_reg = ictl_r;
  assign global_irq_enable = ictl_r[bsr_pkg::GIE_BIT];
  assign phase = ph_r;
  assign idle_cycle = idle_r;
endmodule // bsr_core
`default_nettype wire

// *** hw/bsr_pkg.sv ***
// package: constants and types of the branch, skip and return decoder
package bsr_pkg;
  localparam int unsigned PC_W = 13;
  localparam int unsigned INSN_W = 14;
  localparam int unsigned LIT_W = 11;
  localparam int unsigned FADDR_W = 7;
  localparam int unsigned STACK_DEPTH = 8;
  localparam int unsigned STACK_PTR_W = 3;
  // opcode field positions and codes
  localparam logic [2:0] OPC_JUMP = 3'h5;       // bits 13:11 = 101
  localparam logic [2:0] OPC_CALL = 3'h4;       // bits 13:11 = 100
  localparam logic [5:0] OPC_DECSKIP = 6'h0B;   // bits 13:8 = 00 1011
  localparam logic [3:0] OPC_BITSKIP = 4'h7;    // bits 13:10 = 01 11
  localparam logic [13:0] OPC_IRQRET = 14'h0009;
  localparam logic [13:0] OPC_LOADCFG = 14'h0062;
  localparam int unsigned LATCH_HI_BIT = 4;
  localparam int unsigned LATCH_LO_BIT = 3;
  localparam int unsigned GIE_BIT = 7;
  localparam int unsigned DEST_BIT = 7;
  localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
  localparam logic [7:0] CFG_RESET = 8'hFF;
  localparam logic [7:0] IRQCTL_RESET = 8'h00;
  // instruction phases
  typedef enum logic [1:0] {
    BSR_Q1 = 2'b00,
    BSR_Q2 = 2'b01,
    BSR_Q3 = 2'b10,
    BSR_Q4 = 2'b11
  } bsr_phase_type;
endpackage

// *** hw/bsr_stack.sv ***
// module: circular hardware return stack
`timescale 1ns/1ns
`default_nettype none
module bsr_stack #(
  parameter int unsigned DEPTH = bsr_pkg::STACK_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // stack port
  bsr_stack_if.stack sp
);
  logic [bsr_pkg::PC_W-1:0] mem_r [DEPTH];
  logic [bsr_pkg::STACK_PTR_W-1:0] ptr_r;
  logic [bsr_pkg::STACK_PTR_W-1:0] top_idx;

  // top sits one below the write pointer; wraps on overflow
  assign top_idx = ptr_r - 3'h1;
  assign sp.top = mem_r[top_idx];

  // pointer moves on push or pop
  always_ff @(posedge clk) begin
    if (srst) begin
      ptr_r <= 3'h0;
    end else if (sp.push) begin
      ptr_r <= ptr_r + 3'h1;
    end else if (sp.pop) begin
      ptr_r <= top_idx;
    end
  end

  // entries written on push only
  always_ff @(posedge clk) begin
    if (sp.push) begin
      mem_r[ptr_r] <= sp.push_data;
    end
  end
endmodule // bsr_stack
`default_nettype wire

// *** hw/bsr_stack_if.sv ***
// interface: push and pop path to the return stack
`timescale 1ns/1ns
`default_nettype none
interface bsr_stack_if;
  logic push;
  logic pop;
  logic [12:0] push_data;
  logic [12:0] top;
  modport core (output push, output pop, output push_data, input top);
  modport stack (input push, input pop, input push_data, output top);
endinterface
`default_nettype wire

// *** tb/bsr_monitor.sv ***
// checker: timing relations at the decoder ports
`timescale 1ns/1ns
`default_nettype none
module bsr_monitor (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // watched ports
  input wire logic [13:0] insn,
  input wire logic [12:0] pc,
  input wire logic [7:0] file_rdata,
  input wire logic [7:0] pc_high_latch,
  input wire logic [7:0] work_reg,
  input wire logic [7:0] timer_cfg,
  input wire logic global_irq_enable,
  input wire logic [1:0] phase,
  input wire logic idle_cycle
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // instructions taken in a live Q1
  wire t0 = phase == 2'h0 && !idle_cycle;
  wire jmp = t0 && insn[13:11] == 3'h5;
  wire ret = t0 && insn == 14'h0009;
  wire cfg = t0 && insn == 14'h0062;
  wire dec = t0 && insn[13:7] == 7'h16;
  // relations
  chk_phase_step: assert property (phase != 2'h3 |=> phase == $past(phase) + 2'h1) else $error("phase");
  chk_pc_hold: assert property (phase != 2'h3 |=> $stable(pc)) else $error("pc moved");
  chk_jump_target: assert property (jmp |-> ##4 pc == {$past(pc_high_latch[4:3], 4), $past(insn[10:0], 4)})
    else $error("jump target");
  chk_jump_idle: assert property (jmp |-> ##4 idle_cycle [*4]) else $error("jump idle");
  chk_ret_enable: assert property (ret |-> ##3 global_irq_enable ##1 idle_cycle [*4]) else $error("ret");
  chk_cfg_load: assert property (cfg |-> ##4 timer_cfg == $past(work_reg, 4) && !idle_cycle) else $error("cfg");
  chk_dec_work: assert property (dec |-> ##4 work_reg == $past(file_rdata, 3) - 8'h01) else $error("dec");
  chk_skip_zero: assert property (phase == 2'h1 && !idle_cycle && insn[13:8] == 6'h0B && file_rdata == 8'h01
    |-> ##3 idle_cycle) else $error("skip");
  // main scenarios
  cov_jump: cover property (jmp);
  cov_ret: cover property (ret);
  cov_skip: cover property (dec ##4 idle_cycle);
endmodule // bsr_monitor
bind bsr_core bsr_monitor bsr_monitor_inst (.clk(clk), .srst(srst), .insn(insn), .pc(pc), .file_rdata(file_rdata),
  .pc_high_latch(pc_high_latch), .work_reg(work_reg), .timer_cfg(timer_cfg),
  .global_irq_enable(global_irq_enable), .phase(phase), .idle_cycle(idle_cycle));
`default_nettype wire

// *** tb/tb_top.sv ***
// testbench: directed decoder scenarios
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [13:0] insn = 14'h0000;
  logic [7:0] file_rdata = 8'h00;
  logic [7:0] pc_high_latch = 8'h18;
  logic [12:0] pc;
  logic [7:0] work_reg, timer_cfg, irq_control_reg, file_wdata;
  logic file_we, global_irq_enable, idle_cycle;
  logic [1:0] phase;
  logic [6:0] file_addr;
  int bad_count = 0;
  int tests_run = 0;
  int cyc = 0;
  // device under test
  bsr_core bsr_core_inst (.clk(clk), .srst(srst), .insn(insn), .pc(pc), .file_addr(file_addr), .file_rdata(file_rdata),
    .file_wdata(file_wdata), .file_we(file_we), .pc_high_latch(pc_high_latch), .work_reg(work_reg),
    .timer_cfg(timer_cfg), .irq_control_reg(irq_control_reg), .global_irq_enable(global_irq_enable),
    .phase(phase), .idle_cycle(idle_cycle));
  // clock and hang limit
  always #4 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 1000) begin
      bad_count++;
      results();
    end
  end
  // compare one value
  task automatic chk(input string n, input logic [12:0] e, input logic [12:0] g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  // verdict
  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // one instruction from q1: idle flag, write pulse, address, pc, then the idle cycle ending at pc q
  task automatic ex(input logic [13:0] i, input logic sk, input logic we, input logic [7:0] w,
                    input logic [12:0] p, input logic [12:0] q);
    insn = i;
    repeat (4) @(negedge clk);
    chk("idle_we", {11'h000, sk, we}, {11'h000, idle_cycle, file_we});
    chk("addr", {6'h00, i[6:0]}, {6'h00, file_addr});
    chk("phase", 13'h0000, {11'h000, phase});
    if (we) chk("wdata", {5'h00, w}, {5'h00, file_wdata});
    chk("pc", p, pc);
    if (sk) begin
      repeat (4) @(negedge clk);
      chk("pc_idle", q, pc);
      chk("idle_end", 13'h0000, {12'h000, idle_cycle});
    end
  endtask
  // reset state
  task automatic t_reset();
    chk("rst_pc", 13'h0000, pc);
    chk("rst_cfg", 13'h00FF, {5'h00, timer_cfg});
    chk("rst_irq", 13'h0000, {5'h00, irq_control_reg});
  endtask
  // decrement to working reg, then copy it to timer config
  task automatic t_dec_cfg();
    file_rdata = 8'h3C;
    ex(14'h0B05, 1'b0, 1'b0, 8'h00, 13'h0001, 13'h0001);
    chk("work", 13'h003B, {5'h00, work_reg});
    // config-load is the only path that writes the timer config; it copies the working reg
    ex(14'h0062, 1'b0, 1'b0, 8'h00, 13'h0002, 13'h0002);
    chk("cfg", 13'h003B, {5'h00, timer_cfg});
  endtask
  // decrement to file reaching zero skips
  task automatic t_dec_skip();
    file_rdata = 8'h01;
    ex(14'h0B85, 1'b1, 1'b1, 8'h00, 13'h0003, 13'h0004);
    chk("work_kept", 13'h003B, {5'h00, work_reg});
  endtask
  // bit test skip, set then clear
  task automatic t_bit();
    file_rdata = 8'h80;
    ex(14'h1F85, 1'b1, 1'b0, 8'h00, 13'h0005, 13'h0006);
    file_rdata = 8'h00;
    ex(14'h1F85, 1'b0, 1'b0, 8'h00, 13'h0007, 13'h0007);
  endtask
  // jump with high latch bits
  task automatic t_jump();
    ex(14'h2805, 1'b1, 1'b0, 8'h00, 13'h1805, 13'h1805);
  endtask
  // call then interrupt return to pc plus one
  task automatic t_call_ret();
    ex(14'h2123, 1'b1, 1'b0, 8'h00, 13'h1923, 13'h1923);
    chk("gie_off", 13'h0000, {12'h000, global_irq_enable});
    ex(14'h0009, 1'b1, 1'b0, 8'h00, 13'h1806, 13'h1806);
    chk("irq_ctl", 13'h0080, {5'h00, irq_control_reg});
    chk("gie_on", 13'h0001, {12'h000, global_irq_enable});
  endtask
  // reset in mid-run returns to the start state, then a jump runs again
  task automatic t_mid_reset();
    srst = 1'b1;
    repeat (2) @(negedge clk);
    srst = 1'b0;
    t_reset();
    chk("rst_work", 13'h0000, {5'h00, work_reg});
    chk("rst_idle", 13'h0000, {12'h000, idle_cycle});
    ex(14'h2805, 1'b1, 1'b0, 8'h00, 13'h1805, 13'h1805);
  endtask
  // main sequence
  initial begin
    repeat (12) @(negedge clk);
    srst = 1'b0;
    t_reset();
    t_dec_cfg();
    t_dec_skip();
    t_bit();
    t_jump();
    t_call_ret();
    t_mid_reset();
    results();
  end
endmodule // tb_top
`default_nettype wire
